// file: design/time_interval_counter.sv
// Operation
// RL1: Time chain ticks from crystal, also in power-down.
// RL2: Intervals from one tick to 255 hours.
// RL3: Software allows each access time to complete.
// RL4: Timebase field picks which overflow steps interval.
// RL5: Match of counter and value sets flag.
// RL6: Flag raises interrupt and wakes from power-down.
// RL7: Flag stays set until software clears it.
// RL8: Single-shot timeout clears the interval enable.
// RL9: Otherwise counter reloads and restarts each timeout.
// RL10: Interval counter runs only while enabled.
// RL11: Clock enable gates ticks; clearing restores time.
// RL12: Time registers writable while clock enable low.
// RL13: Hour counts 0-23 in 24-hour mode, else 0-255.
// RL14: Interval value register accepts 0 to 255.
// RL15: Hundredths counts 0-127 then carries to seconds.
// RL16: Seconds counts 0-59 then carries to minutes.
// RL17: Minutes counts 0-59 then carries to hours.
// RL18: Enabling the interval clears its counter.
`timescale 1ns/100ps
`default_nettype none
module time_interval_counter #(
   parameter int XTAL_DIV = tic_pkg::XTAL_PER_TICK
) (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic xtal_i,
   input wire tic_pkg::byte_t sfr_addr_i,
   input wire logic sfr_wr_i,
   input wire tic_pkg::byte_t sfr_wdata_i,
   input wire logic sfr_rd_i,
   output tic_pkg::byte_t sfr_rdata_o,
   input wire logic int_enable_i,
   input wire logic power_down_i,
   output logic irq_o,
   output logic wake_o,
   output tic_pkg::vector_t wake_vector_o
);
   import tic_pkg::*;

   logic tick_en;
   logic clk_en_reg;
   logic ien_reg;
   logic flag_reg;
   logic single_reg;
   logic hour24_reg;
   timebase_e tb_reg;
   byte_t interval_match_value_reg;
   byte_t ival_cnt_reg;
   byte_t ival_next;
   byte_t rdata_reg;
   logic ctl_wr;
   logic iv_wr;
   logic restore;
   logic ien_rise;
   logic tb_pulse;
   logic timeout;
   logic [STAGES-1:0] time_wr;
   logic [STAGES-1:0] stage_inc;
   logic [STAGES-1:0] stage_wrap;
   byte_t stage_max [STAGES];
   byte_t time_cnt [STAGES];
   byte_t shadow_reg [STAGES];

   // The logic needs at least two crystal edges per tick.
   generate
      if (XTAL_DIV < 2) begin : g_bad_ratio
         $error("crystal ratio must be at least two");
      end
   endgenerate

   // The crystal tick is not gated by power-down; only the clock enable gates it.
   tic_tick_divider #(
      .DIV(XTAL_DIV)
   ) u_divider (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .xtal_i(xtal_i),
      .tick_o(tick_en)
   ); // [RL1]

   assign ctl_wr = sfr_wr_i && (sfr_addr_i == ADDR_CONTROL);
   assign iv_wr = sfr_wr_i && (sfr_addr_i == ADDR_INTERVAL_MATCH_VALUE);
   assign restore = ctl_wr && clk_en_reg && !sfr_wdata_i[BIT_CLK_EN]; // [RL11]
   assign ien_rise = ctl_wr && !ien_reg && sfr_wdata_i[BIT_IEN];

   assign stage_inc[0] = tick_en && clk_en_reg; // [RL11]
   assign stage_max[0] = HUND_MAX; // [RL15]
   assign stage_max[1] = SEC_MAX; // [RL16]
   assign stage_max[2] = MIN_MAX; // [RL17]
   assign stage_max[3] = hour24_reg ? HOUR24_MAX : HOUR_FULL_MAX; // [RL13]

   // Each time stage carries into the next one.
   genvar i;
   generate
      for (i = 0; i < STAGES; i++) begin : g_stage
         byte_t stage_addr;
         assign stage_addr = byte_t'(ADDR_HUND + i);
         assign time_wr[i] = sfr_wr_i && (sfr_addr_i == stage_addr) && !clk_en_reg; // [RL12]
         if (i > 0) begin : g_carry
            assign stage_inc[i] = stage_wrap[i-1]; // [RL15] [RL16] [RL17]
         end

         always_ff @(posedge ref_clk_i) begin
            if (rst_i) begin
               shadow_reg[i] <= TIME_RESET;
            end else if (time_wr[i]) begin
               shadow_reg[i] <= sfr_wdata_i; // [RL11]
            end
         end

         tic_wrap_counter #(
            .WIDTH(8)
         ) u_count (
            .ref_clk_i(ref_clk_i),
            .rst_i(rst_i),
            .inc_i(stage_inc[i]),
            .load_i(time_wr[i] || restore),
            .load_val_i(time_wr[i] ? sfr_wdata_i : shadow_reg[i]),
            .max_i(stage_max[i]),
            .count_o(time_cnt[i]),
            .wrap_o(stage_wrap[i])
         );
      end
   endgenerate

   // The selected overflow steps the interval counter.
   always_comb begin
      case (tb_reg)
         TB_TICK: tb_pulse = stage_inc[0]; // [RL4]
         TB_SEC: tb_pulse = stage_wrap[0]; // [RL4]
         TB_MIN: tb_pulse = stage_wrap[1]; // [RL4]
         TB_HOUR: tb_pulse = stage_wrap[2]; // [RL4]
         default: tb_pulse = 1'b0;
      endcase
   end

   assign ival_next = ival_cnt_reg + 8'h01;
   // A value of N from 1 to 255 gives N timebase units and 0 gives 256; 255 with hour units is 255 hours.
   assign timeout = ien_reg && tb_pulse && (ival_next == interval_match_value_reg); // [RL5] [RL2]

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         ival_cnt_reg <= 8'h00;
      end else if (ien_rise) begin
         ival_cnt_reg <= 8'h00; // [RL18]
      end else if (timeout) begin
         ival_cnt_reg <= 8'h00; // [RL9]
      end else if (ien_reg && tb_pulse) begin
         ival_cnt_reg <= ival_next; // [RL10]
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         ien_reg <= CONTROL_RESET[BIT_IEN];
      end else if (ctl_wr) begin
         ien_reg <= sfr_wdata_i[BIT_IEN]; // [RL10]
      end else if (timeout && single_reg) begin
         ien_reg <= 1'b0; // [RL8]
      end
   end

   // The hardware set wins over a software clear in the same cycle.
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         flag_reg <= CONTROL_RESET[BIT_FLAG];
      end else if (timeout) begin
         flag_reg <= 1'b1; // [RL5] [RL7]
      end else if (ctl_wr) begin
         flag_reg <= sfr_wdata_i[BIT_FLAG]; // [RL7]
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         clk_en_reg <= CONTROL_RESET[BIT_CLK_EN];
         single_reg <= CONTROL_RESET[BIT_SINGLE];
         hour24_reg <= CONTROL_RESET[BIT_HOUR24];
         tb_reg <= timebase_e'(CONTROL_RESET[BIT_TB_HI:BIT_TB_LO]);
      end else if (ctl_wr) begin
         clk_en_reg <= sfr_wdata_i[BIT_CLK_EN];
         single_reg <= sfr_wdata_i[BIT_SINGLE];
         hour24_reg <= sfr_wdata_i[BIT_HOUR24];
         tb_reg <= timebase_e'(sfr_wdata_i[BIT_TB_HI:BIT_TB_LO]);
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         interval_match_value_reg <= INTERVAL_MATCH_VALUE_RESET;
      end else if (iv_wr) begin
         interval_match_value_reg <= sfr_wdata_i; // [RL14]
      end
   end

   // Read data is captured on the read strobe; the reserved bit reads zero.
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         rdata_reg <= 8'h00;
      end else if (sfr_rd_i) begin
         case (sfr_addr_i)
            ADDR_CONTROL: rdata_reg <= {1'b0, hour24_reg, tb_reg, single_reg,
                                        flag_reg, ien_reg, clk_en_reg};
            ADDR_HUND: rdata_reg <= time_cnt[0];
            ADDR_SEC: rdata_reg <= time_cnt[1];
            ADDR_MIN: rdata_reg <= time_cnt[2];
            ADDR_HOUR: rdata_reg <= time_cnt[3];
            ADDR_INTERVAL_MATCH_VALUE: rdata_reg <= interval_match_value_reg;
            default: rdata_reg <= 8'h00;
         endcase
      end
   end

   assign sfr_rdata_o = rdata_reg;
   assign irq_o = flag_reg && int_enable_i; // [RL6]
   assign wake_o = irq_o && power_down_i; // [RL6]
   assign wake_vector_o = WAKE_VECTOR; // [RL6]

   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (rst_i);

   a_tick_spacing: assert property (tick_en |=> !tick_en [*8]) // [RL1]
      else $error("crystal tick repeated too soon");
   a_timebase_step: assert property (ien_reg && tb_pulse && !timeout && !ctl_wr
      |=> ival_cnt_reg == $past(ival_next)) // [RL4]
      else $error("interval counter did not step on the selected overflow");
   a_flag_on_match: assert property (timeout |=> flag_reg) // [RL5]
      else $error("match did not set the interval flag");
   a_irq_on_flag: assert property ($rose(flag_reg) && int_enable_i
      |-> irq_o && (wake_o == power_down_i)) // [RL6]
      else $error("interrupt or wake missing after flag set");
   a_flag_sticky: assert property (flag_reg && !ctl_wr |=> flag_reg) // [RL7]
      else $error("interval flag cleared without software");
   a_single_stop: assert property (timeout && single_reg && !ctl_wr
      |=> !ien_reg && ival_cnt_reg == 8'h00) // [RL8]
      else $error("single-shot timeout left the interval enabled");
   a_periodic_reload: assert property (timeout && !single_reg && !ctl_wr
      |=> ien_reg && ival_cnt_reg == 8'h00) // [RL9]
      else $error("periodic timeout did not reload the counter");
   a_counter_frozen: assert property (!ien_reg && !ctl_wr |=> $stable(ival_cnt_reg)) // [RL10]
      else $error("interval counter moved while disabled");
   a_time_restore: assert property (restore |=> time_cnt[0] == $past(shadow_reg[0])
      && time_cnt[3] == $past(shadow_reg[3]) && !clk_en_reg) // [RL11]
      else $error("time registers not restored on clock disable");
   a_time_preset: assert property (time_wr[1] |=> time_cnt[1] == $past(sfr_wdata_i)) // [RL12]
      else $error("seconds preset not taken");
   a_hour_range: assert property (hour24_reg && time_cnt[3] <= 8'h17 && !time_wr[3]
      && !restore && !ctl_wr |=> time_cnt[3] <= 8'h17) // [RL13]
      else $error("hour counter left the 24-hour range");
   a_interval_match_value_write: assert property (iv_wr |=> interval_match_value_reg == $past(sfr_wdata_i)) // [RL14]
      else $error("interval value write lost");
   a_hund_wrap: assert property (stage_inc[0] && time_cnt[0] == 8'h7F && !restore
      |=> time_cnt[0] == 8'h00 && time_cnt[1] != $past(time_cnt[1])) // [RL15]
      else $error("hundredths did not wrap into seconds");
   a_sec_wrap: assert property (stage_inc[1] && time_cnt[1] == 8'h3B && !restore
      |-> stage_inc[2]) // [RL16]
      else $error("seconds did not carry into minutes");
   a_min_wrap: assert property (stage_inc[2] && time_cnt[2] == 8'h3B && !restore
      |-> stage_inc[3]) // [RL17]
      else $error("minutes did not carry into hours");
   a_enable_clear: assert property (ien_rise |=> ival_cnt_reg == 8'h00 && ien_reg) // [RL18]
      else $error("interval counter not cleared on enable");


   // Guards for stopped time, refused writes, full-range hours and read data.
   a_time_frozen: assert property (!clk_en_reg && !time_wr[0] |=> $stable(time_cnt[0])) // [RL11]
      else $error("hundredths moved while the time clock was off");
   a_write_refused: assert property (clk_en_reg && sfr_wr_i && sfr_addr_i == ADDR_SEC
      && !stage_inc[1] |=> $stable(time_cnt[1])) // [RL12]
      else $error("seconds written while the time clock ran");
   a_hour_full: assert property (!hour24_reg && stage_inc[3] && time_cnt[3] == 8'hFE
      && !restore && !time_wr[3] |=> time_cnt[3] == 8'hFF) // [RL13]
      else $error("hour counter stopped short of the full range");
   a_read_interval_match_value: assert property (sfr_rd_i && sfr_addr_i == ADDR_INTERVAL_MATCH_VALUE
      |=> sfr_rdata_o == $past(interval_match_value_reg)) // [RL14]
      else $error("interval value read back wrong");

   c_single_shot: cover property (timeout && single_reg);
   c_periodic: cover property (timeout && !single_reg ##[1:1000] timeout);
   c_restore: cover property (restore);
   c_wake: cover property (wake_o);
endmodule
`default_nettype wire

// file: design/tic_pkg.sv
package tic_pkg;

   typedef logic [7:0] byte_t;
   typedef logic [15:0] vector_t;

   // Register addresses in the special function register space.
   localparam byte_t ADDR_CONTROL = 8'hA1;
   localparam byte_t ADDR_HUND = 8'hA2;
   localparam byte_t ADDR_SEC = 8'hA3;
   localparam byte_t ADDR_MIN = 8'hA4;
   localparam byte_t ADDR_HOUR = 8'hA5;
   localparam byte_t ADDR_INTERVAL_MATCH_VALUE = 8'hA6;

   // Field positions of counter_control.
   localparam int BIT_CLK_EN = 0;
   localparam int BIT_IEN = 1;
   localparam int BIT_FLAG = 2;
   localparam int BIT_SINGLE = 3;
   localparam int BIT_TB_LO = 4;
   localparam int BIT_TB_HI = 5;
   localparam int BIT_HOUR24 = 6;

   // Reset values.
   localparam byte_t CONTROL_RESET = 8'h00;
   localparam byte_t INTERVAL_MATCH_VALUE_RESET = 8'h00;
   localparam byte_t TIME_RESET = 8'h00;

   // Last count of each time stage.
   localparam byte_t HUND_MAX = 8'h7F;
   localparam byte_t SEC_MAX = 8'h3B;
   localparam byte_t MIN_MAX = 8'h3B;
   localparam byte_t HOUR24_MAX = 8'h17;
   localparam byte_t HOUR_FULL_MAX = 8'hFF;

   // Crystal rate and the time tick derived from it.
   localparam int XTAL_HZ = 32768;
   localparam int TICK_HZ = 128;
   localparam int XTAL_PER_TICK = XTAL_HZ / TICK_HZ;
   localparam int STAGES = 4;

   // Wake-up service vector.
   localparam vector_t WAKE_VECTOR = 16'h0053;

   typedef enum logic [1:0] {
      TB_TICK = 2'b00,
      TB_SEC = 2'b01,
      TB_MIN = 2'b10,
      TB_HOUR = 2'b11
   } timebase_e;

endpackage

// file: design/tic_tick_divider.sv
`timescale 1ns/100ps
`default_nettype none
module tic_tick_divider #(
   parameter int DIV = 256
) (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic xtal_i,
   output logic tick_o
);
   localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
   localparam logic [CW-1:0] LAST = CW'(DIV - 1);

   logic xtal_meta_reg;
   logic xtal_sync_reg;
   logic xtal_last_reg;
   logic [CW-1:0] cnt_reg;
   logic rise;

   generate
      if (DIV < 2) begin : g_bad_div
         $error("tick divider needs a ratio of at least two");
      end
   endgenerate

   // The crystal pin passes two flip-flops before the edge detector.
   always_ff @(posedge ref_clk_i) begin
      xtal_meta_reg <= xtal_i;
      xtal_sync_reg <= xtal_meta_reg;
      xtal_last_reg <= xtal_sync_reg;
   end

   assign rise = xtal_sync_reg && !xtal_last_reg;

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         cnt_reg <= '0;
      end else if (rise) begin
         cnt_reg <= (cnt_reg == LAST) ? '0 : cnt_reg + 1'b1;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         tick_o <= 1'b0;
      end else begin
         tick_o <= rise && (cnt_reg == LAST);
      end
   end
endmodule
`default_nettype wire

// file: design/tic_wrap_counter.sv
`timescale 1ns/100ps
`default_nettype none
module tic_wrap_counter #(
   parameter int WIDTH = 8
) (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic inc_i,
   input wire logic load_i,
   input wire logic [WIDTH-1:0] load_val_i,
   input wire logic [WIDTH-1:0] max_i,
   output logic [WIDTH-1:0] count_o,
   output logic wrap_o
);
   generate
      if (WIDTH < 1) begin : g_bad_width
         $error("wrap counter needs a width of at least one");
      end
   endgenerate

   // A load wins over counting and suppresses the carry.
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         count_o <= '0;
      end else if (load_i) begin
         count_o <= load_val_i;
      end else if (inc_i) begin
         count_o <= (count_o == max_i) ? '0 : count_o + 1'b1;
      end
   end

   assign wrap_o = inc_i && !load_i && (count_o == max_i);
endmodule
`default_nettype wire

// file: tb/time_interval_counter_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module time_interval_counter_tb_top;
   import tic_pkg::*;
   localparam int XD = 2;
   logic ref_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic xtal_i = 1'b0;
   byte_t sfr_addr_i = 8'h00;
   logic sfr_wr_i = 1'b0;
   byte_t sfr_wdata_i = 8'h00;
   logic sfr_rd_i = 1'b0;
   byte_t sfr_rdata_o;
   logic int_enable_i = 1'b0;
   logic power_down_i = 1'b0;
   logic irq_o;
   logic wake_o;
   vector_t wake_vector_o;
   int miscompares = 0;
   int comparisons = 0;
   int cycles = 0;
   logic [31:0] seed = 32'h0000552B;
   int t[4];
   int sh[4];
   int clk_en, ien, flg, one_shot, tb, h24, ival, cnt;

   time_interval_counter #(.XTAL_DIV(XD)) dut (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .xtal_i(xtal_i),
      .sfr_addr_i(sfr_addr_i),
      .sfr_wr_i(sfr_wr_i),
      .sfr_wdata_i(sfr_wdata_i),
      .sfr_rd_i(sfr_rd_i),
      .sfr_rdata_o(sfr_rdata_o),
      .int_enable_i(int_enable_i),
      .power_down_i(power_down_i),
      .irq_o(irq_o),
      .wake_o(wake_o),
      .wake_vector_o(wake_vector_o)
   );

   always #20 ref_clk_i = ~ref_clk_i;

   always @(posedge ref_clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         miscompares++;
         final_report();
      end
   end

   function automatic logic [31:0] lfsr(logic [31:0] x);
      return {1'b0, x[31:1]} ^ (x[0] ? 32'h80200003 : 32'h00000000);
   endfunction

   task automatic final_report();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic cmp_byte(string n, byte_t e, byte_t g);
      comparisons++;
      if (g !== e) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic cmp_bit(string n, logic e, logic g);
      comparisons++;
      if (g !== e) begin
         miscompares++;
         $display("wrong value %s expected %b seen %b", n, e, g);
      end
   endtask

   // One access at a time, each held for a full cycle.
   task automatic wr(byte_t a, byte_t d);
      @(posedge ref_clk_i);
      sfr_addr_i <= a;
      sfr_wdata_i <= d;
      sfr_wr_i <= 1'b1;
      @(posedge ref_clk_i);
      sfr_wr_i <= 1'b0;
      if (a == ADDR_CONTROL) begin
         if (clk_en && !d[BIT_CLK_EN])
            t = sh;
         if (!ien && d[BIT_IEN])
            cnt = 0;
         clk_en = d[BIT_CLK_EN];
         ien = d[BIT_IEN];
         flg = d[BIT_FLAG];
         one_shot = d[BIT_SINGLE];
         tb = d[BIT_TB_HI:BIT_TB_LO];
         h24 = d[BIT_HOUR24];
      end else if (a == ADDR_INTERVAL_MATCH_VALUE) begin
         ival = d;
      end else if (a >= ADDR_HUND && a <= ADDR_HOUR && !clk_en) begin
         t[a - ADDR_HUND] = d;
         sh[a - ADDR_HUND] = d;
      end
   endtask

   task automatic rd(byte_t a, byte_t e, string n);
      @(posedge ref_clk_i);
      sfr_addr_i <= a;
      sfr_rd_i <= 1'b1;
      @(posedge ref_clk_i);
      sfr_rd_i <= 1'b0;
      #1;
      cmp_byte(n, e, sfr_rdata_o);
   endtask

   task automatic m_tick();
      int c;
      int w[4];
      int mx[4];
      int step;
      if (!clk_en)
         return;
      mx = '{127, 59, 59, h24 ? 23 : 255};
      c = 1;
      for (int i = 0; i < 4; i++) begin
         w[i] = c && t[i] == mx[i];
         if (c)
            t[i] = w[i] ? 0 : t[i] + 1;
         c = w[i];
      end
      step = tb == 0 ? 1 : w[tb - 1];
      if (ien && step) begin
         if ((cnt + 1) % 256 == ival) begin
            flg = 1;
            cnt = 0;
            if (one_shot)
               ien = 0;
         end else begin
            cnt++;
         end
      end
   endtask

   task automatic ticks(int n);
      repeat (n * XD) begin
         @(posedge ref_clk_i);
         xtal_i <= 1'b1;
         repeat (4) @(posedge ref_clk_i);
         xtal_i <= 1'b0;
         repeat (3) @(posedge ref_clk_i);
      end
      repeat (6) @(posedge ref_clk_i);
      repeat (n) m_tick();
   endtask

   task automatic check_all();
      byte_t c;
      c = {1'b0, h24[0], tb[1:0], one_shot[0], flg[0], ien[0], clk_en[0]};
      rd(ADDR_CONTROL, c, "control");
      for (int i = 0; i < 4; i++)
         rd(byte_t'(ADDR_HUND + i), byte_t'(t[i]), "time");
      rd(ADDR_INTERVAL_MATCH_VALUE, byte_t'(ival), "interval value");
      rd(8'hA7, 8'h00, "unmapped");
      seed = lfsr(seed);
      int_enable_i <= seed[0];
      power_down_i <= seed[1];
      @(posedge ref_clk_i);
      #1;
      cmp_bit("irq", flg[0] & seed[0], irq_o);
      cmp_bit("wake", flg[0] & seed[0] & seed[1], wake_o);
   endtask

   initial begin
      repeat (4) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      check_all();
      cmp_byte("vector hi", WAKE_VECTOR[15:8], wake_vector_o[15:8]);
      cmp_byte("vector lo", WAKE_VECTOR[7:0], wake_vector_o[7:0]);
      for (int k = 0; k < 3; k++) begin
         wr(ADDR_CONTROL, k == 0 ? 8'h40 : 8'h00);
         wr(ADDR_HUND, HUND_MAX - 8'h01);
         wr(ADDR_SEC, SEC_MAX);
         wr(ADDR_MIN, MIN_MAX);
         wr(ADDR_HOUR, k == 2 ? HOUR_FULL_MAX : HOUR24_MAX);
         wr(ADDR_CONTROL, k == 0 ? 8'h41 : 8'h01);
         ticks(2);
         check_all();
         wr(ADDR_SEC, 8'h05);
         check_all();
         wr(ADDR_CONTROL, 8'h00);
         ticks(1);
         check_all();
      end
      seed = lfsr(seed);
      wr(ADDR_INTERVAL_MATCH_VALUE, {5'h00, seed[2:0]} | 8'h02);
      wr(ADDR_CONTROL, 8'h03);
      repeat (2) begin
         ticks(ival);
         check_all();
         ticks(1);
         check_all();
         wr(ADDR_CONTROL, 8'h03);
      end
      wr(ADDR_CONTROL, 8'h01);
      wr(ADDR_CONTROL, 8'h03);
      ticks(ival - 1);
      check_all();
      wr(ADDR_CONTROL, 8'h01);
      wr(ADDR_CONTROL, 8'h0B);
      ticks(ival);
      check_all();
      ticks(ival);
      check_all();
      for (int k = 1; k < 4; k++) begin
         wr(ADDR_CONTROL, 8'h00);
         wr(ADDR_HUND, HUND_MAX - 8'h01);
         wr(ADDR_SEC, k > 1 ? SEC_MAX : 8'h00);
         wr(ADDR_MIN, k > 2 ? MIN_MAX : 8'h00);
         wr(ADDR_INTERVAL_MATCH_VALUE, 8'h01);
         wr(ADDR_CONTROL, {2'b00, 2'(k), 4'h3});
         ticks(1);
         check_all();
         ticks(1);
         check_all();
      end
      wr(ADDR_CONTROL, 8'h00);
      wr(ADDR_INTERVAL_MATCH_VALUE, 8'h00);
      wr(ADDR_CONTROL, 8'h03);
      ticks(255);
      check_all();
      ticks(1);
      check_all();
      final_report();
   end
endmodule
`default_nettype wire
